/* File: wdtr_map.vh */
// Watchdog register map, field positions, reset values and timing constants
`ifndef WDTR_MAP_VH
`define WDTR_MAP_VH

// ------------------------------------------------------------
// Register indices and byte addresses (index times four)
// ------------------------------------------------------------
`define WDTR_IDX_UNITS       8'h52
`define WDTR_IDX_VALUE       8'h53
`define WDTR_IDX_CFG         8'h54
`define WDTR_IDX_CTRL        8'h55
`define WDTR_ADDR_UNITS      12'h148
`define WDTR_ADDR_VALUE      12'h14c
`define WDTR_ADDR_CFG        12'h150
`define WDTR_ADDR_CTRL       12'h154
`define WDTR_ADDR_W          12

// ------------------------------------------------------------
// Register select codes
// ------------------------------------------------------------
`define WDTR_SEL_NONE        3'h0
`define WDTR_SEL_UNITS       3'h1
`define WDTR_SEL_VALUE       3'h2
`define WDTR_SEL_CFG         3'h3
`define WDTR_SEL_CTRL        3'h4

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define WDTR_UNITS_SEC_BIT   7
`define WDTR_CFG_JOY_BIT     0
`define WDTR_CFG_KBD_BIT     1
`define WDTR_CFG_MOUSE_BIT   2
`define WDTR_CFG_MAP_HI      7
`define WDTR_CFG_MAP_LO      4
`define WDTR_CTRL_STAT_BIT   0
`define WDTR_CTRL_FORCE_BIT  2
`define WDTR_CTRL_KBCEN_BIT  3

// ------------------------------------------------------------
// Reset values and special codes
// ------------------------------------------------------------
`define WDTR_RST_BYTE        8'h00
`define WDTR_RST_MAP         4'h0
`define WDTR_MAP_OFF         4'h0
`define WDTR_MAP_BAD         4'h2
`define WDTR_CNT_ZERO        8'h00
`define WDTR_CNT_ONE         8'h01
`define WDTR_IRQ_NONE        16'h0000
`define WDTR_IRQ_ONE         16'h0001

// ------------------------------------------------------------
// Timing: times in their own unit, cycles derived
// ------------------------------------------------------------
`define WDTR_PCLK_NS         100
`define WDTR_SECOND_NS       1000000000
`define WDTR_SEC_PER_MIN     60
`define WDTR_SEC_CYCLES      (`WDTR_SECOND_NS / `WDTR_PCLK_NS)
`define WDTR_DIV_W           24
`define WDTR_MIN_W           6

`endif

/* File: wdtr_unit_tick.v */
// Second and minute tick divider for the watchdog countdown
`timescale 1ns/1ps
`default_nettype none
`include "wdtr_map.vh"

module wdtr_unit_tick #(
  parameter SEC_CYCLES = `WDTR_SEC_CYCLES
) (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Control
  input  wire restart,
  input  wire units_sec,
  // Tick out
  output reg  unit_tick
);

  reg  [`WDTR_DIV_W-1:0] div_r;
  reg  [`WDTR_MIN_W-1:0] sec_r;
  wire                   sec_end;
  wire                   min_end;

  // Full-width terminal counts, cut on purpose to the counter widths
  localparam [31:0]            DIV_LAST_W = SEC_CYCLES - 1;
  localparam [31:0]            SEC_LAST_W = `WDTR_SEC_PER_MIN - 1;
  localparam [`WDTR_DIV_W-1:0] DIV_LAST   = DIV_LAST_W[`WDTR_DIV_W-1:0];
  localparam [`WDTR_MIN_W-1:0] SEC_LAST   = SEC_LAST_W[`WDTR_MIN_W-1:0];

  assign sec_end = (div_r == DIV_LAST);
  assign min_end = sec_end && (sec_r == SEC_LAST);

  // Restart realigns both stages so a full unit follows a reload
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r     <= {`WDTR_DIV_W{1'b0}};
      sec_r     <= {`WDTR_MIN_W{1'b0}};
      unit_tick <= 1'b0;
    end else if (restart) begin
      div_r     <= {`WDTR_DIV_W{1'b0}};
      sec_r     <= {`WDTR_MIN_W{1'b0}};
      unit_tick <= 1'b0;
    end else begin
      div_r     <= sec_end ? {`WDTR_DIV_W{1'b0}} : div_r + 1'b1;
      if (sec_end)
        sec_r   <= min_end ? {`WDTR_MIN_W{1'b0}} : sec_r + 1'b1;
      unit_tick <= units_sec ? sec_end : min_end;
    end
  end

endmodule
`default_nettype wire

/* File: wdtr_top.v */
// Watchdog timer with selectable restart sources and APB registers
//
// How it works
// - Units bit 7 clear counts minutes, set counts seconds.
// - Timeout value is binary unit count; zero disables timeout.
// - Nonzero value N gives N units, one up to 255.
// - Config bit 0 lets joystick port accesses restart the count.
// - Config bit 1 lets keyboard interrupts restart the count.
// - Config bit 2 lets mouse interrupts restart the count.
// - Config bits 7:4 select interrupt line; zero off, two invalid.
// - Control bit 0 is status, set on timeout, cleared by writing zero.
// - Writing control bit 2 forces a timeout; bit clears itself.
// - Control bit 3 lets force-line rising edges force timeouts.
// - Control bit 3 clear ignores the force line entirely.
// - Force line edge detected self-clearing, ORed with software force.
// - Units bits 6:2 read zero; reserved control bits written zero.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wdtr_map.vh"

module wdtr_top #(
  parameter SEC_CYCLES = `WDTR_SEC_CYCLES
) (
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // Restart sources
  input  wire        joy_access,
  input  wire        kbd_irq,
  input  wire        mouse_irq,
  // Force line from keyboard controller
  input  wire        kbc_force_line,
  // Watchdog outputs
  output reg  [15:0] irq_req,
  output reg         timeout_pulse
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------

  // Map a byte address onto a register select code
  function [2:0] reg_sel;
    input [`WDTR_ADDR_W-1:0] a;
    begin
      case (a)
        `WDTR_ADDR_UNITS: reg_sel = `WDTR_SEL_UNITS;
        `WDTR_ADDR_VALUE: reg_sel = `WDTR_SEL_VALUE;
        `WDTR_ADDR_CFG:   reg_sel = `WDTR_SEL_CFG;
        `WDTR_ADDR_CTRL:  reg_sel = `WDTR_SEL_CTRL;
        default:          reg_sel = `WDTR_SEL_NONE;
      endcase
    end
  endfunction

  // One-hot request line from the mapping field
  function [15:0] irq_decode;
    input [3:0] map;
    begin
      if (map == `WDTR_MAP_OFF || map == `WDTR_MAP_BAD)
        irq_decode = `WDTR_IRQ_NONE;
      else
        irq_decode = `WDTR_IRQ_ONE << map;
    end
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire       upper_zero;
  wire [2:0] sel;
  wire       setup_ph;
  wire       wr_acc;
  wire       wr_units;
  wire       wr_value;
  wire       wr_cfg;
  wire       wr_ctrl;

  // Anything above the decoded window is unmapped
  assign upper_zero = (paddr[31:`WDTR_ADDR_W] == {(32-`WDTR_ADDR_W){1'b0}});
  assign sel        = upper_zero ? reg_sel(paddr[`WDTR_ADDR_W-1:0])
                                 : `WDTR_SEL_NONE;
  assign setup_ph   = psel && !penable;
  assign wr_acc     = psel && penable && pwrite;
  assign wr_units   = wr_acc && (sel == `WDTR_SEL_UNITS);
  assign wr_value   = wr_acc && (sel == `WDTR_SEL_VALUE);
  assign wr_cfg     = wr_acc && (sel == `WDTR_SEL_CFG);
  assign wr_ctrl    = wr_acc && (sel == `WDTR_SEL_CTRL);

  // No wait states: data is prepared in the setup cycle
  assign pready = 1'b1;

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  reg       units_sec_r;
  reg [7:0] value_r;
  reg [2:0] src_en_r;
  reg [3:0] irq_map_r;
  reg       kbc_en_r;

  // Plain storage; reserved bits are simply not kept
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      units_sec_r <= 1'b0;
      value_r     <= `WDTR_RST_BYTE;
      src_en_r    <= 3'b000;
      irq_map_r   <= `WDTR_RST_MAP;
      kbc_en_r    <= 1'b0;
    end else begin
      if (wr_units)
        units_sec_r <= pwdata[`WDTR_UNITS_SEC_BIT];
      if (wr_value)
        value_r     <= pwdata[7:0];
      if (wr_cfg) begin
        src_en_r    <= pwdata[`WDTR_CFG_MOUSE_BIT:`WDTR_CFG_JOY_BIT];
        irq_map_r   <= pwdata[`WDTR_CFG_MAP_HI:`WDTR_CFG_MAP_LO];
      end
      if (wr_ctrl)
        kbc_en_r    <= pwdata[`WDTR_CTRL_KBCEN_BIT];
    end
  end

  // ------------------------------------------------------------
  // Input synchronisers and edge detectors
  // ------------------------------------------------------------
  reg [2:0] kbc_sync_r;
  reg [2:0] kbd_sync_r;
  reg [2:0] mouse_sync_r;

  // Stage 0 only feeds stage 1; edges look at stages 1 and 2
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kbc_sync_r   <= 3'b000;
      kbd_sync_r   <= 3'b000;
      mouse_sync_r <= 3'b000;
    end else begin
      kbc_sync_r   <= {kbc_sync_r[1:0], kbc_force_line};
      kbd_sync_r   <= {kbd_sync_r[1:0], kbd_irq};
      mouse_sync_r <= {mouse_sync_r[1:0], mouse_irq};
    end
  end

  wire kbc_rise;
  wire kbd_rise;
  wire mouse_rise;

  // one pulse per rising edge, however long the line stays high
  assign kbc_rise   = kbc_sync_r[1] && !kbc_sync_r[2];
  assign kbd_rise   = kbd_sync_r[1] && !kbd_sync_r[2];
  assign mouse_rise = mouse_sync_r[1] && !mouse_sync_r[2];

  // ------------------------------------------------------------
  // Force sources
  // ------------------------------------------------------------
  reg  sw_force_r;
  wire kbc_force;
  wire force_evt;

  // write-only force bit, cleared by hardware next cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sw_force_r <= 1'b0;
    else
      sw_force_r <= wr_ctrl && pwdata[`WDTR_CTRL_FORCE_BIT];
  end

  // force line edges count only while enabled
  // with the enable clear the line is ignored
  assign kbc_force = kbc_rise && kbc_en_r;
  // line edge ORed with software force
  assign force_evt = sw_force_r || kbc_force;

  // ------------------------------------------------------------
  // Restart sources
  // ------------------------------------------------------------
  wire src_restart;
  wire reload;
  wire [7:0] reload_val;

  // joystick port accesses restart when enabled
  assign src_restart = (joy_access && src_en_r[`WDTR_CFG_JOY_BIT])
                    || (kbd_rise && src_en_r[`WDTR_CFG_KBD_BIT])
                    || (mouse_rise && src_en_r[`WDTR_CFG_MOUSE_BIT]);

  // value or units writes also reload, with the new value
  assign reload     = src_restart || wr_value || wr_units;
  assign reload_val = wr_value ? pwdata[7:0] : value_r;

  // ------------------------------------------------------------
  // Unit divider
  // ------------------------------------------------------------
  wire unit_tick;
  wire units_sec_nxt;

  // New units take effect together with the reload
  assign units_sec_nxt = wr_units ? pwdata[`WDTR_UNITS_SEC_BIT]
                                  : units_sec_r;

  wdtr_unit_tick #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_tick (
    .pclk      (pclk),
    .presetn   (presetn),
    .restart   (reload),
    .units_sec (units_sec_nxt),
    .unit_tick (unit_tick)
  );

  // ------------------------------------------------------------
  // Countdown
  // ------------------------------------------------------------
  reg  [7:0] count_r;
  reg  [7:0] count_nxt;
  wire       expire;

  // the tick that takes the count from one to zero ends N units
  assign expire = unit_tick && !reload && (count_r == `WDTR_CNT_ONE);

  // Reload beats a tick arriving in the same cycle
  always @* begin
    count_nxt = count_r;
    if (reload)
      count_nxt = reload_val;
    else if (unit_tick && count_r != `WDTR_CNT_ZERO)
      count_nxt = count_r - 1'b1;
  end

  // a zero value never counts, so never expires
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      count_r <= `WDTR_CNT_ZERO;
    else
      count_r <= count_nxt;
  end

  // ------------------------------------------------------------
  // Status flag and interrupt
  // ------------------------------------------------------------
  reg  status_r;
  reg  status_nxt;
  wire timeout_evt;

  assign timeout_evt = expire || force_evt;

  // a timeout set wins over a software clear in the same cycle
  always @* begin
    status_nxt = status_r;
    if (wr_ctrl)
      status_nxt = pwdata[`WDTR_CTRL_STAT_BIT];
    if (timeout_evt)
      status_nxt = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r      <= 1'b0;
      timeout_pulse <= 1'b0;
      irq_req       <= `WDTR_IRQ_NONE;
    end else begin
      status_r      <= status_nxt;
      timeout_pulse <= timeout_evt;
      // mapped line; disabled or invalid code drives none
      // request held while the status flag stands
      irq_req       <= status_nxt ? irq_decode(irq_map_r) : `WDTR_IRQ_NONE;
    end
  end

  // ------------------------------------------------------------
  // Read data and error
  // ------------------------------------------------------------
  reg [7:0] rd_byte;

  // reserved and write-only bits read as zero
  always @* begin
    case (sel)
      `WDTR_SEL_UNITS: rd_byte = {units_sec_r, 7'h00};
      `WDTR_SEL_VALUE: rd_byte = value_r;
      `WDTR_SEL_CFG:   rd_byte = {irq_map_r, 1'b0, src_en_r};
      `WDTR_SEL_CTRL:  rd_byte = {4'h0, kbc_en_r, 2'b00, status_r};
      default:         rd_byte = `WDTR_RST_BYTE;
    endcase
  end

  // Captured in setup so the access phase finishes at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= {24'h00_0000, rd_byte};
      pslverr <= (sel == `WDTR_SEL_NONE);
    end
  end

endmodule
`default_nettype wire

/* File: wdtr_sva.sv */
// Port-level assertion checker for the watchdog top level
`timescale 1ns/1ps
`default_nettype none

module wdtr_sva (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Watchdog outputs
  input wire logic [15:0] irq_req,
  input wire logic        timeout_pulse
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle of a read; read data loads in the setup cycle of any access
  wire rd_setup;
  assign rd_setup = psel && !penable && !pwrite;

  a_ready_const: assert property (pready)
    else $error("pready dropped");
  a_rdata_upper: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_irq_onehot: assert property ($onehot0(irq_req))
    else $error("more than one interrupt line high");
  a_pulse_single: assert property (timeout_pulse |=> !timeout_pulse)
    else $error("timeout pulse longer than one cycle");
  a_unmap_err: assert property (
    psel && !penable && !(paddr inside {32'h148, 32'h14c, 32'h150, 32'h154})
    |=> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_units_rsvd: assert property (
    rd_setup && paddr == 32'h148 |=> prdata[6:2] == 5'h0 && !pslverr)
    else $error("units register reserved bits not zero");
  a_ctrl_rsvd: assert property (
    rd_setup && paddr == 32'h154 |=> prdata[7:4] == 4'h0 && !prdata[2])
    else $error("control write-only or reserved bits read back");
  a_resp_hold: assert property (
    psel && penable |=> $stable(prdata) && $stable(pslverr))
    else $error("read response changed outside setup");

  // Main scenarios reached
  c_expiry: cover property ($rose(timeout_pulse));
  c_irq_top: cover property (irq_req[15]);
  c_refused: cover property (psel && penable && pslverr);
endmodule

bind wdtr_top wdtr_sva chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq_req(irq_req), .timeout_pulse(timeout_pulse)
);

`default_nettype wire

/* File: wdtr_top_tb.sv */
// Self-checking bench for the watchdog top level
`timescale 1ns/1ps
`default_nettype none

module wdtr_top_tb;
  // Short second keeps minute runs brief
  localparam int SC = 4;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [31:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [2:0]  srcs = 0;
  logic [2:0]  smask = 0;
  logic        kbc = 0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [15:0] irq_req;
  wire         timeout_pulse;
  int          err_total = 0;
  int          num_checks = 0;
  int          npulse = 0;
  int          n;
  int          p;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  u [5] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h00};
  logic [7:0]  v [5] = '{8'h01, 8'h02, 8'hff, 8'h01, 8'h02};

  wdtr_top #(.SEC_CYCLES(SC)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .joy_access(srcs[0]),
    .kbd_irq(srcs[1]), .mouse_irq(srcs[2]), .kbc_force_line(kbc),
    .irq_req(irq_req), .timeout_pulse(timeout_pulse)
  );

  // Clock and pulse tally
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (timeout_pulse === 1'b1) npulse <= npulse + 1;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; a stuck wait is ended by the hang guard
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 8'h0);
    chk(rd, e);
  endtask

  // Counts edges to the next timeout pulse, pulsing restart sources
  task automatic wait_pulse(input int mx);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      srcs <= (n % 6 == 0 && n <= 30) ? smask : 3'h0;
      #1;
    end while (timeout_pulse !== 1'b1 && n < mx);
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 4; i++) rdc(12'h148 + 4 * i, 0);
    apb(0, 12'h158, 8'h0);
    chk(er, 1); // unmapped refused
    chk(rd, 0); // unmapped reads zero
    apb(1, 12'h148, 8'hff);
    apb(0, 12'h148, 8'h0);
    chk(rd & 32'hfc, 32'h80);
    $display("test reset done");
  endtask

  task automatic t_expiry;
    for (int i = 0; i < 5; i++) begin
      apb(1, 12'h150, 8'h30);
      apb(1, 12'h148, u[i]);
      apb(1, 12'h14c, v[i]);
      wait_pulse(2000);
      chk(n, (u[i][7] ? SC : 60 * SC) * v[i] + 1);
      chk(irq_req, 32'h8);
      rdc(12'h154, 1);
      apb(1, 12'h154, 8'h0);
      rdc(12'h154, 0);
      chk(irq_req, 0);
    end
    $display("test expiry done");
  endtask

  task automatic t_force;
    apb(1, 12'h14c, 8'h0);
    for (int m = 0; m < 16; m++) begin
      apb(1, 12'h150, m[3:0] << 4);
      apb(1, 12'h154, 8'h04);
      wait_pulse(20);
      chk(n, 1);
      chk(irq_req, (m == 0 || m == 2) ? 0 : 32'h1 << m);
      rdc(12'h154, 1);
      apb(1, 12'h154, 8'h0);
    end
    // Seconds, so a zero read as 256 units would show inside the wait
    apb(1, 12'h148, 8'h80);
    p = npulse;
    repeat (1100) @(posedge pclk);
    chk(npulse - p, 0);
    $display("test force done");
  endtask

  task automatic t_restart;
    for (int s = 0; s < 3; s++) begin
      for (int e = 0; e < 2; e++) begin
        apb(1, 12'h150, e ? 8'h1 << s : 8'h0);
        apb(1, 12'h148, 8'h80);
        apb(1, 12'h14c, 8'h02);
        smask = 3'h1 << s;
        wait_pulse(100);
        smask = 0;
        chk(n > 30, e);
        apb(1, 12'h154, 8'h0);
      end
    end
    $display("test restart done");
  endtask

  task automatic t_kbc;
    apb(1, 12'h14c, 8'h0);
    p = npulse;
    @(posedge pclk);
    kbc <= 1;
    repeat (20) @(posedge pclk);
    chk(npulse - p, 0);
    apb(1, 12'h154, 8'h08);
    repeat (20) @(posedge pclk);
    chk(npulse - p, 0);
    kbc <= 0;
    repeat (5) @(posedge pclk);
    kbc <= 1;
    repeat (40) @(posedge pclk);
    chk(npulse - p, 1);
    apb(1, 12'h154, 8'h0c);
    wait_pulse(20);
    chk(n, 1);
    kbc <= 0;
    $display("test force line done");
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_expiry;
    t_force;
    t_restart;
    t_kbc;
    final_report;
  end

  // Hang guard, well beyond the planned run length
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    final_report;
  end
endmodule

`default_nettype wire
